// file: dbm_pkg.sv
// Package for the dual byte match timer core.
// Holds register indices, field positions, reset values and AHB transfer and response codes.
package dbm_pkg;

	localparam int          DBM_AW = 16;
	// Register indices; byte address is four times the index
	localparam logic [15:0] DBM_IDX_CONTROL     = 16'hFE18;
	localparam logic [15:0] DBM_IDX_PRESCALE    = 16'hFE19;
	localparam logic [15:0] DBM_IDX_LOW_COUNT   = 16'hFE1A;
	localparam logic [15:0] DBM_IDX_HIGH_COUNT  = 16'hFE1B;
	localparam logic [15:0] DBM_IDX_LOW_MATCH   = 16'hFE1C;
	localparam logic [15:0] DBM_IDX_HIGH_MATCH  = 16'hFE1D;

	localparam logic [7:0]  DBM_RST_CONTROL     = 8'h00;
	localparam logic [7:0]  DBM_RST_PRESCALE    = 8'h00;
	localparam logic [7:0]  DBM_RST_COUNT       = 8'h00;
	localparam logic [7:0]  DBM_RST_MATCH       = 8'h00;

	// Control register fields
	localparam int          DBM_B_HIGH_RUN      = 7;
	localparam int          DBM_B_LOW_RUN       = 6;
	localparam int          DBM_B_LENGTH_SEL    = 5;
	localparam int          DBM_B_OUT_MODE      = 4;
	localparam int          DBM_B_HIGH_FLAG     = 3;
	localparam int          DBM_B_HIGH_IRQ_EN   = 2;
	localparam int          DBM_B_LOW_FLAG      = 1;
	localparam int          DBM_B_LOW_IRQ_EN    = 0;

	// Prescale register fields: four-bit groups, top bit turns dividing on
	localparam int          DBM_PRE_HIGH_LSB    = 4;
	localparam int          DBM_PRE_LOW_LSB     = 0;
	localparam int          DBM_PRE_ON_BIT      = 3;

	localparam logic [1:0]  DBM_HTRANS_NONSEQ   = 2'h2;
	localparam logic        DBM_RESP_OKAY       = 1'h0;

endpackage

// file: dbm_prescaler.sv
// Programmable power-of-two prescaler for one byte of the timer.
// Assumes hclk domain; step is a same-clock enable, load a same-clock pulse.
`timescale 1ns/1ps
`default_nettype none
module dbm_prescaler
	import dbm_pkg::*;
(
	input  wire logic       hclk,
	input  wire logic       hresetn,
	input  wire logic       run,
	input  wire logic       step,
	input  wire logic       load,
	input  wire logic [3:0] code,
	output logic            tick
);
	import dbm_pkg::*;

	logic [3:0] code_q;
	logic [3:0] code_d;
	logic [7:0] cnt_q;
	logic [7:0] cnt_d;
	logic [7:0] last_w;

	// Divide-by minus one: 0 for prescale 1, else 2^(c[2:0]+1)-1
	function automatic logic [7:0] div_last(input logic [3:0] c);
		logic [8:0] full;
		// Widened sum so code 7 shifts by 8 instead of wrapping to 0
		full = 9'h001 << ({1'b0, c[2:0]} + 4'h1);
		div_last = c[DBM_PRE_ON_BIT] ? 8'(full - 9'h001) : 8'h00;
	endfunction

	assign last_w = div_last(code_q);
	assign tick   = run & step & (cnt_q == last_w);
	// New code only at buffer reload; held while running to avoid a torn period
	assign code_d = (!run || load) ? code : code_q;
	assign cnt_d  = !run ? 8'h00 : (step ? (tick ? 8'h00 : 8'(cnt_q + 8'h01)) : cnt_q);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			code_q <= 4'h0;
			cnt_q  <= 8'h00;
		end else begin
			code_q <= code_d;
			cnt_q  <= cnt_d;
		end
	end

endmodule
`default_nettype wire

// file: dbm_timer_core.sv
// Dual byte match timer core with AHB-Lite register slave.
// Assumes one hclk domain at 100 MHz and a single-slave AHB-Lite bus.
//
// Summary of operation
// - Interrupt request when high irq enable and high zero flag both set.
// - Low zero flag sets when running low counter reaches zero.
// - Interrupt request when low irq enable and low zero flag both set.
// - Flags never self-clear; software writes zero to clear them.
// - Prescale rewrite while running applies at that byte's buffer reload.
// - High prescale from bits 7..4: off gives 1, else 2 to 256.
// - Low prescale from bits 3..0: off gives 1, else 2 to 256.
// - Low counter counts up on low prescaler ticks; read only.
// - High counter counts up on high prescaler ticks; read only.
// - Low match event when low buffer equals low count.
// - High match event when high buffer equals high count.
// - Low buffer follows data when stopped, reloads at zero when running.
// - High buffer follows data when stopped, reloads at zero when running.
// - Run bit low holds counter at zero; high lets it count.
// - Length select chains high byte to low interval; both matches remain.
// - Low clears on match in modes 0,2; high in modes 0,2,3.
// - High zero flag sets when running high counter reaches zero.
`timescale 1ns/1ps
`default_nettype none
module dbm_timer_core
	import dbm_pkg::*;
(
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic [31:0]      hrdata,
	output logic             hreadyout,
	output logic             hresp,
	output logic             irq_req,
	output logic             low_match_pulse,
	output logic             high_match_pulse
);
	import dbm_pkg::*;

	logic [7:0]  ctrl_q;
	logic [7:0]  ctrl_d;
	logic [7:0]  pre_q;
	logic [7:0]  lmd_q;
	logic [7:0]  hmd_q;
	logic [7:0]  lcnt_q;
	logic [7:0]  lcnt_d;
	logic [7:0]  hcnt_q;
	logic [7:0]  hcnt_d;
	logic [7:0]  lbuf_q;
	logic [7:0]  hbuf_q;
	logic [7:0]  lbuf_d;
	logic [7:0]  hbuf_d;
	logic        wr_pend_q;
	logic [15:0] wr_idx_q;
	logic [31:0] rdata_q;
	logic        lmatch_q;
	logic        hmatch_q;

	// Bus decode
	wire         bus_take  = hsel & hready & (htrans == DBM_HTRANS_NONSEQ);
	wire [15:0]  addr_idx  = haddr[17:2];
	wire         wr_ctrl   = wr_pend_q & (wr_idx_q == DBM_IDX_CONTROL);
	wire         wr_pre    = wr_pend_q & (wr_idx_q == DBM_IDX_PRESCALE);
	wire         wr_lmd    = wr_pend_q & (wr_idx_q == DBM_IDX_LOW_MATCH);
	wire         wr_hmd    = wr_pend_q & (wr_idx_q == DBM_IDX_HIGH_MATCH);
	wire [7:0]   wbyte     = hwdata[7:0];

	// Control fields
	wire         high_run_ctrl      = ctrl_q[DBM_B_HIGH_RUN];
	wire         low_run_ctrl       = ctrl_q[DBM_B_LOW_RUN];
	wire         length_select      = ctrl_q[DBM_B_LENGTH_SEL];
	wire         output_mode_select = ctrl_q[DBM_B_OUT_MODE];
	wire         high_zero_flag     = ctrl_q[DBM_B_HIGH_FLAG];
	wire         high_irq_enable    = ctrl_q[DBM_B_HIGH_IRQ_EN];
	wire         low_zero_flag      = ctrl_q[DBM_B_LOW_FLAG];
	wire         low_irq_enable     = ctrl_q[DBM_B_LOW_IRQ_EN];

	// Match compare on the buffers, not the data registers
	wire         low_match  = (lbuf_q == lcnt_q);
	wire         high_match = (hbuf_q == hcnt_q);

	// Mode = {length_select, output_mode_select}; low clears in modes 0,2, high in all but mode 1
	wire         low_clr_on_match  = ~output_mode_select;
	wire         high_clr_on_match = length_select | ~output_mode_select;

	wire         low_tick;
	wire         high_tick;
	wire [7:0]   lcnt_inc = 8'(lcnt_q + 8'h01);
	wire [7:0]   hcnt_inc = 8'(hcnt_q + 8'h01);
	wire         low_wrap  = low_tick & ((low_match & low_clr_on_match) | (lcnt_inc == 8'h00));
	wire         high_wrap = high_tick & ((high_match & high_clr_on_match) | (hcnt_inc == 8'h00));

	// Chained mode steps the high prescaler once per low interval
	wire         high_step = length_select ? low_wrap : 1'b1;

	dbm_prescaler u_low_pre (
		.hclk    (hclk),
		.hresetn (hresetn),
		.run     (low_run_ctrl),
		.step    (1'b1),
		.load    (low_wrap),
		.code    (pre_q[DBM_PRE_LOW_LSB +: 4]),
		.tick    (low_tick)
	);

	dbm_prescaler u_high_pre (
		.hclk    (hclk),
		.hresetn (hresetn),
		.run     (high_run_ctrl),
		.step    (high_step),
		.load    (high_wrap),
		.code    (pre_q[DBM_PRE_HIGH_LSB +: 4]),
		.tick    (high_tick)
	);

	// Counters: zero while stopped, step on tick, clear at wrap
	assign lcnt_d = !low_run_ctrl ? 8'h00 : (low_wrap ? 8'h00 : (low_tick ? lcnt_inc : lcnt_q));
	assign hcnt_d = !high_run_ctrl ? 8'h00 : (high_wrap ? 8'h00 : (high_tick ? hcnt_inc : hcnt_q));

	// Buffers track data when stopped; reload only as the count reaches zero
	assign lbuf_d = (!low_run_ctrl || low_wrap) ? lmd_q : lbuf_q;
	assign hbuf_d = (!high_run_ctrl || high_wrap) ? hmd_q : hbuf_q;

	// Flags: hardware set beats a software clear in the same cycle
	always_comb begin
		ctrl_d = ctrl_q;
		if (wr_ctrl) begin
			ctrl_d = wbyte;
			ctrl_d[DBM_B_HIGH_FLAG] = high_zero_flag & wbyte[DBM_B_HIGH_FLAG];
			ctrl_d[DBM_B_LOW_FLAG]  = low_zero_flag & wbyte[DBM_B_LOW_FLAG];
		end
		if (high_run_ctrl && high_wrap) begin
			ctrl_d[DBM_B_HIGH_FLAG] = 1'b1;
		end
		if (low_run_ctrl && low_wrap) begin
			ctrl_d[DBM_B_LOW_FLAG] = 1'b1;
		end
	end

	// Read mux; count registers have no write path at all
	function automatic logic [7:0] rd_mux(input logic [15:0] idx, input logic [7:0] c,
		input logic [7:0] p, input logic [7:0] l, input logic [7:0] h,
		input logic [7:0] lm, input logic [7:0] hm);
		case (idx)
			DBM_IDX_CONTROL:    rd_mux = c;
			DBM_IDX_PRESCALE:   rd_mux = p;
			DBM_IDX_LOW_COUNT:  rd_mux = l;
			DBM_IDX_HIGH_COUNT: rd_mux = h;
			DBM_IDX_LOW_MATCH:  rd_mux = lm;
			DBM_IDX_HIGH_MATCH: rd_mux = hm;
			default:            rd_mux = 8'h00;
		endcase
	endfunction

	wire [7:0] rd_byte = rd_mux(addr_idx, ctrl_q, pre_q, lcnt_q, hcnt_q, lmd_q, hmd_q);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_q <= 1'b0;
			wr_idx_q  <= 16'h0000;
			rdata_q   <= 32'h0000_0000;
		end else begin
			wr_pend_q <= bus_take & hwrite;
			if (bus_take) begin
				wr_idx_q <= addr_idx;
			end
			// Sampled at address phase: a count read sees the value one cycle early
			if (bus_take && !hwrite) begin
				rdata_q <= {24'h00_0000, rd_byte};
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_q <= DBM_RST_CONTROL;
			pre_q  <= DBM_RST_PRESCALE;
			lmd_q  <= DBM_RST_MATCH;
			hmd_q  <= DBM_RST_MATCH;
		end else begin
			ctrl_q <= ctrl_d;
			if (wr_pre) begin
				pre_q <= wbyte;
			end
			if (wr_lmd) begin
				lmd_q <= wbyte;
			end
			if (wr_hmd) begin
				hmd_q <= wbyte;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			lcnt_q   <= DBM_RST_COUNT;
			hcnt_q   <= DBM_RST_COUNT;
			lbuf_q   <= DBM_RST_MATCH;
			hbuf_q   <= DBM_RST_MATCH;
			lmatch_q <= 1'b0;
			hmatch_q <= 1'b0;
		end else begin
			lcnt_q   <= lcnt_d;
			hcnt_q   <= hcnt_d;
			lbuf_q   <= lbuf_d;
			hbuf_q   <= hbuf_d;
			lmatch_q <= low_tick & low_match;
			hmatch_q <= high_tick & high_match;
		end
	end

	assign hrdata           = rdata_q;
	assign hreadyout        = 1'b1;
	assign hresp            = DBM_RESP_OKAY;
	assign low_match_pulse  = lmatch_q;
	assign high_match_pulse = hmatch_q;
	// One level request for the shared vector
	assign irq_req = (high_irq_enable & high_zero_flag)
		| (low_irq_enable & low_zero_flag);

endmodule
`default_nettype wire

// file: dbm_timer_core_asserts.sv
// Port checker for the timer core.
// Assumes one slave, hready fed from hreadyout.
`timescale 1ns/1ps
`default_nettype none
module dbm_chk (
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [2:0]  hsize,
	input wire logic [31:0] hwdata,
	input wire logic        hready,
	input wire logic [31:0] hrdata,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic        irq_req,
	input wire logic        low_match_pulse,
	input wire logic        high_match_pulse
);
	import dbm_pkg::*;
	logic        wr_q, rd_q;
	logic [15:0] idx_q;
	logic [7:0]  ctl_q, pre_q;
	logic [2:0]  lr_q, hr_q;
	wire take = hsel && hready && htrans == DBM_HTRANS_NONSEQ;
	wire ctl_wr = wr_q && idx_q == DBM_IDX_CONTROL;
	// Flags masked: hardware may set them
	wire ctl_rd = rd_q && idx_q == DBM_IDX_CONTROL;
	wire pre_rd = rd_q && idx_q == DBM_IDX_PRESCALE;
	wire bad_rd = rd_q && (idx_q < DBM_IDX_CONTROL || idx_q > DBM_IDX_HIGH_MATCH);
	wire lstop = !ctl_q[6] && lr_q == 3'h0;
	wire hstop = !ctl_q[7] && hr_q == 3'h0;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			{wr_q, rd_q, idx_q, ctl_q, pre_q, lr_q, hr_q} <= '0;
		end else begin
			wr_q <= take && hwrite;
			rd_q <= take && !hwrite;
			idx_q <= haddr[17:2];
			lr_q <= {lr_q[1:0], ctl_q[6]};
			hr_q <= {hr_q[1:0], ctl_q[7]};
			if (ctl_wr) ctl_q <= hwdata[7:0] & 8'hF5;
			if (wr_q && idx_q == DBM_IDX_PRESCALE) pre_q <= hwdata[7:0];
		end
	end
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	pre_read_a: assert property (pre_rd |-> hrdata == {24'h0, pre_q})
		else $error("prescale readback wrong");
	ctl_read_a: assert property (ctl_rd |-> (hrdata & 32'hFFFFFFF5) == {24'h0, ctl_q})
		else $error("control readback wrong");
	unmapped_a: assert property (bad_rd |-> hrdata == 32'h0)
		else $error("unmapped read not zero");
	irq_gate_a: assert property (irq_req |-> ctl_q[2] || ctl_q[0])
		else $error("irq without enable");
	irq_hold_a: assert property (irq_req && !ctl_wr |=> irq_req)
		else $error("irq dropped without write");
	low_stop_a: assert property (lstop |-> !low_match_pulse)
		else $error("low match while stopped");
	high_stop_a: assert property (hstop |-> !high_match_pulse)
		else $error("high match while stopped");
	cnt_stop_a: assert property (rd_q && (idx_q == DBM_IDX_LOW_COUNT && lstop
		|| idx_q == DBM_IDX_HIGH_COUNT && hstop) |-> hrdata == 32'h0)
		else $error("stopped count not zero");
	resp_okay_a: assert property (hresp == DBM_RESP_OKAY && hreadyout)
		else $error("response not okay or not ready");
	rdata_top_a: assert property (rd_q |-> hrdata[31:8] == 24'h0)
		else $error("read data upper bits set");
	cover property ($rose(irq_req));
	cover property (low_match_pulse);
	cover property (high_match_pulse);
endmodule
`default_nettype wire

// file: tb.sv
// Self-checking bench for the timer core.
// Bench acts as the only AHB-Lite master.
`timescale 1ns/1ps
`default_nettype none
module tb;
	import dbm_pkg::*;
	logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
	logic [31:0] haddr = '0, hwdata = '0, rd, hrdata;
	logic [1:0]  htrans = '0;
	logic [2:0]  hsize = 3'h2;
	logic        hreadyout, hresp, irq_req, lp, hp;
	int          n_mismatch = 0, n_tests = 0;
	always #5 hclk = ~hclk;
	dbm_timer_core i_dbm_timer_core (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.irq_req(irq_req), .low_match_pulse(lp), .high_match_pulse(hp));
	task automatic report_and_stop();
		$display("Mismatches %0d, checks %0d", n_mismatch, n_tests);
		if (n_mismatch == 0 && n_tests > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Bounded wait so a stuck slave cannot hang the run
	task automatic rdy();
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 50);
		if (n >= 50) begin
			n_mismatch++;
			report_and_stop();
		end
	endtask
	task automatic bus(input logic w, input logic [15:0] idx, input logic [7:0] wd);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= DBM_HTRANS_NONSEQ;
		haddr <= {14'h0, idx, 2'h0};
		hwrite <= w;
		rdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {24'h0, wd};
		rdy();
		rd = hrdata;
	endtask
	task automatic rchk(input logic [15:0] idx, input logic [7:0] exp);
		bus(1'b0, idx, 8'h00);
		chk(rd, {24'h0, exp});
	endtask
	task automatic wpulse(input bit h, output int c);
		c = 0;
		do begin
			@(posedge hclk);
			#1;
			c++;
		end while ((h ? hp : lp) !== 1'b1 && c < 2000);
		chk(c < 2000, 1);
		if (c >= 2000) report_and_stop();
	endtask
	// Counts run but slowly, so a leaked count write would stick
	task automatic t_reset();
		for (int i = 0; i < 6; i++)
			rchk(DBM_IDX_CONTROL + 16'(i), 8'h00);
		rchk(16'h0000, 8'h00);
		bus(1'b1, DBM_IDX_PRESCALE, 8'hFF);
		bus(1'b1, DBM_IDX_CONTROL, 8'hC0);
		bus(1'b1, DBM_IDX_LOW_COUNT, 8'h55);
		bus(1'b1, DBM_IDX_HIGH_COUNT, 8'hAA);
		rchk(DBM_IDX_LOW_COUNT, 8'h00);
		rchk(DBM_IDX_HIGH_COUNT, 8'h00);
		bus(1'b1, DBM_IDX_CONTROL, 8'h00);
		bus(1'b1, DBM_IDX_PRESCALE, 8'h00);
	endtask
	task automatic t_irq(input bit h);
		logic [7:0] e, f, r;
		int n;
		e = h ? 8'h04 : 8'h01;
		f = e << 1;
		r = h ? 8'h80 : 8'h40;
		bus(1'b1, h ? DBM_IDX_HIGH_MATCH : DBM_IDX_LOW_MATCH, 8'h01);
		bus(1'b1, DBM_IDX_CONTROL, r | e);
		n = 0;
		while (irq_req !== 1'b1 && n < 50) begin
			@(posedge hclk);
			n++;
		end
		chk(n < 50, 1);
		if (n >= 50) report_and_stop();
		rchk(DBM_IDX_CONTROL, r | e | f);
		bus(1'b1, DBM_IDX_CONTROL, e | f);
		rchk(DBM_IDX_CONTROL, e | f);
		chk(irq_req, 1);
		bus(1'b1, DBM_IDX_CONTROL, e);
		rchk(DBM_IDX_CONTROL, e);
		chk(irq_req, 0);
	endtask
	// Pulse spacing is (match + 1) ticks of the prescale
	task automatic t_pre(input bit h);
		int c;
		logic [3:0] f;
		bus(1'b1, h ? DBM_IDX_HIGH_MATCH : DBM_IDX_LOW_MATCH, 8'h01);
		for (int k = 0; k < 9; k++) begin
			f = k < 8 ? 4'(8 + k) : 4'h0;
			bus(1'b1, DBM_IDX_CONTROL, 8'h00);
			bus(1'b1, DBM_IDX_PRESCALE, h ? {f, 4'h0} : {4'h0, f});
			bus(1'b1, DBM_IDX_CONTROL, h ? 8'h80 : 8'h40);
			wpulse(h, c);
			wpulse(h, c);
			chk(c, k < 8 ? 4 << k : 2);
		end
		bus(1'b1, DBM_IDX_CONTROL, 8'h00);
	endtask
	task automatic t_long();
		int c;
		bus(1'b1, DBM_IDX_CONTROL, 8'hE0);
		wpulse(1'b1, c);
		wpulse(1'b1, c);
		chk(c, 4);
	endtask
	// Rewrites while running wait for the next wrap; 506 = 512 less two bus calls
	task automatic t_reload();
		int c;
		bus(1'b1, DBM_IDX_CONTROL, 8'h00);
		bus(1'b1, DBM_IDX_PRESCALE, 8'h0F);
		bus(1'b1, DBM_IDX_LOW_MATCH, 8'h01);
		bus(1'b1, DBM_IDX_CONTROL, 8'h40);
		wpulse(1'b0, c);
		bus(1'b1, DBM_IDX_PRESCALE, 8'h00);
		bus(1'b1, DBM_IDX_LOW_MATCH, 8'h03);
		wpulse(1'b0, c);
		chk(c, 506);
		wpulse(1'b0, c);
		chk(c, 4);
		bus(1'b1, DBM_IDX_CONTROL, 8'h00);
	endtask
	initial begin
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		t_reset();
		t_irq(1'b0);
		t_irq(1'b1);
		t_pre(1'b0);
		t_pre(1'b1);
		t_long();
		t_reload();
		report_and_stop();
	end
endmodule
bind dbm_timer_core dbm_chk i_dbm_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
	.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
	.hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
	.irq_req(irq_req), .low_match_pulse(low_match_pulse),
	.high_match_pulse(high_match_pulse));
`default_nettype wire
